//--- core/sms_pkg.sv
package sms_pkg;

   // ****************************************************************
   // Operating modes and command codes.
   // ****************************************************************

   // Operating modes of the chip.
   typedef enum logic [2:0] {
      SMS_INIT,
      SMS_NORMAL,
      SMS_STOP,
      SMS_SLEEP,
      SMS_RESTART,
      SMS_FAILSAFE
   } sms_mode_type;

   // Values of the mode select bits written over SPI.
   localparam logic [1:0] MODE_SEL_NORMAL = 2'h0;
   localparam logic [1:0] MODE_SEL_SLEEP = 2'h1;
   localparam logic [1:0] MODE_SEL_STOP = 2'h2;
   localparam logic [1:0] MODE_SEL_RESET = 2'h3;

   // ****************************************************************
   // Frame layout and timing.
   // ****************************************************************

   localparam int SPI_BITS = 16;
   localparam int CMD_POS = 15;
   localparam int MODE_POS = 0;
   localparam int TRIG_POS = 2;
   localparam int CFG_POS = 3;
   localparam int LIMIT_POS = 4;
   localparam logic [3:0] CNT_RESET = 4'h0;
   localparam logic [1:0] MISS_RESET = 2'h0;
   localparam int MAX_WD_RESETS = 3;

   localparam int CLK_MHZ = 50;
   localparam int RESET_DELAY_US = 10;
   localparam int RESET_DELAY_CYC = RESET_DELAY_US * CLK_MHZ;
   localparam int LONG_WINDOW_MS = 200;
   localparam int LONG_WINDOW_CYC = LONG_WINDOW_MS * 1000 * CLK_MHZ;

   // Decoded SPI frame handed from the link domain.
   typedef struct packed {
      logic write;
      logic [1:0] mode_sel;
      logic trigger;
      logic cfg_sel;
      logic limit;
   } sms_cmd_type;

endpackage

//--- core/sms_core.sv
`timescale 1ns/1ps
module sms_core #(
   parameter int RESET_DELAY = sms_pkg::RESET_DELAY_CYC,
   parameter int LONG_WINDOW = sms_pkg::LONG_WINDOW_CYC
) (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic sclk_i,
   input wire logic csn_i,
   input wire logic mosi_i,
   input wire logic supply_above_rt_i,
   input wire logic supply_above_uvto_i,
   input wire logic wake_i,
   input wire logic critical_fail_i,
   input wire logic overtemp_i,
   input wire logic soft_reset_i,
   input wire logic strap_pin_i,
   output logic strap_pin_o,
   output logic strap_pin_oe_o,
   output logic reset_output_n_o,
   output logic main_supply_en_o,
   output logic fail_outputs_o,
   output logic main_supply_undervoltage_flag_o,
   output logic test_indication_o,
   output logic config_state_bit_o,
   output logic watchdog_fail_o,
   output sms_pkg::sms_mode_type mode_o
);

   // ****************************************************************
   // Link domain: shift in 16-bit frames on the SPI clock.
   // ****************************************************************

   logic [sms_pkg::SPI_BITS-1:0] shift;
   logic [sms_pkg::SPI_BITS-1:0] next_shift;
   logic [3:0] bit_cnt;
   logic [3:0] next_bit_cnt;
   logic [sms_pkg::SPI_BITS-1:0] frame;
   logic [sms_pkg::SPI_BITS-1:0] next_frame;
   logic frame_tgl;
   logic next_frame_tgl;

   // Counts bits of the frame; the sixteenth completes it.
   always_comb begin
      next_shift = {shift[sms_pkg::SPI_BITS-2:0], mosi_i};
      next_bit_cnt = bit_cnt + 4'h1;
      next_frame = frame;
      next_frame_tgl = frame_tgl;
      if (csn_i) begin
         next_bit_cnt = sms_pkg::CNT_RESET;
      end else if (bit_cnt == 4'hf) begin
         next_frame = next_shift;
         next_frame_tgl = ~frame_tgl;
      end
   end

   // Link clock stops outside frames; reset clears count and toggle, which would otherwise start unknown.
   always_ff @(posedge sclk_i or posedge reset_i) begin
      if (reset_i) begin
         bit_cnt <= sms_pkg::CNT_RESET;
         frame_tgl <= 1'b0;
      end else begin
         shift <= next_shift;
         bit_cnt <= next_bit_cnt;
         frame <= next_frame;
         frame_tgl <= next_frame_tgl;
      end
   end

   // ****************************************************************
   // Crossings into the main clock domain.
   // ****************************************************************

   logic [2:0] tgl_sync;
   logic [1:0] rt_sync;
   logic [1:0] uvto_sync;
   logic [1:0] wake_sync;
   logic [1:0] crit_sync;
   logic [1:0] ot_sync;
   logic [1:0] strap_sync;
   logic frame_evt;
   sms_pkg::sms_cmd_type cmd;

   // Two flops per level; a third stage feeds the toggle edge detector.
   always_ff @(posedge mclk_i) begin
      tgl_sync <= {tgl_sync[1:0], frame_tgl};
      rt_sync <= {rt_sync[0], supply_above_rt_i};
      uvto_sync <= {uvto_sync[0], supply_above_uvto_i};
      wake_sync <= {wake_sync[0], wake_i};
      crit_sync <= {crit_sync[0], critical_fail_i};
      ot_sync <= {ot_sync[0], overtemp_i};
      strap_sync <= {strap_sync[0], strap_pin_i};
   end

   // The frame register is stable for many clocks after the toggle lands.
   assign frame_evt = tgl_sync[2] ^ tgl_sync[1];
   assign cmd.write = frame[sms_pkg::CMD_POS];
   assign cmd.mode_sel = frame[sms_pkg::MODE_POS+1:sms_pkg::MODE_POS];
   assign cmd.trigger = frame[sms_pkg::TRIG_POS];
   assign cmd.cfg_sel = frame[sms_pkg::CFG_POS];
   assign cmd.limit = frame[sms_pkg::LIMIT_POS];

   // ****************************************************************
   // Mode state machine and watchdog.
   // ****************************************************************

   sms_pkg::sms_mode_type mode;
   sms_pkg::sms_mode_type next_mode;
   logic [31:0] dly_cnt;
   logic [31:0] next_dly_cnt;
   logic [31:0] wd_cnt;
   logic [31:0] next_wd_cnt;
   logic [1:0] miss_cnt;
   logic [1:0] next_miss_cnt;
   logic [1:0] wd_resets;
   logic [1:0] next_wd_resets;
   logic [1:0] mode_bits;
   logic [1:0] next_mode_bits;
   logic test_ind;
   logic next_test_ind;
   logic cfg_state;
   logic next_cfg_state;
   logic limit_bit;
   logic next_limit_bit;
   logic fail_out;
   logic next_fail_out;
   logic wd_fail;
   logic next_wd_fail;
   logic uv_flag;
   logic next_uv_flag;
   logic rst_n;
   logic next_rst_n;
   logic wd_expired;
   logic wd_event;

   // Long open window expiry; halted in development mode.
   assign wd_expired = (wd_cnt == 32'(LONG_WINDOW - 1)) && !test_ind;
   assign wd_event = wd_expired && (cfg_state || miss_cnt != 2'h0);

   // Next mode, timers and configuration.
   always_comb begin
      next_mode = mode;
      next_dly_cnt = dly_cnt;
      next_wd_cnt = wd_cnt;
      next_miss_cnt = miss_cnt;
      next_wd_resets = wd_resets;
      next_mode_bits = mode_bits;
      next_test_ind = test_ind;
      next_cfg_state = cfg_state;
      next_limit_bit = limit_bit;
      next_fail_out = fail_out;
      next_wd_fail = wd_fail;
      next_uv_flag = uv_flag;
      next_rst_n = rst_n;
      if (frame_evt && cmd.write) begin
         next_cfg_state = cmd.cfg_sel;
         next_limit_bit = cmd.limit;
         next_mode_bits = cmd.mode_sel;
      end
      if (mode == sms_pkg::SMS_NORMAL || mode == sms_pkg::SMS_STOP) begin
         next_wd_cnt = test_ind ? wd_cnt : wd_cnt + 32'h1;
         if (frame_evt && cmd.trigger) begin
            next_wd_cnt = '0;
            next_miss_cnt = sms_pkg::MISS_RESET;
            next_wd_resets = 2'h0;
         end else if (wd_expired) begin
            next_wd_cnt = '0;
            next_wd_fail = 1'b1;
            if (!wd_event) begin
               next_miss_cnt = miss_cnt + 2'h1;
            end
         end
         if (!rt_sync[1] && uvto_sync[1]) begin
            next_uv_flag = 1'b1;
         end
      end
      case (mode)
         sms_pkg::SMS_INIT: begin
            next_rst_n = 1'b0;
            next_test_ind = ~strap_sync[1];
            if (rt_sync[1]) begin
               if (rst_n) begin
                  next_rst_n = 1'b1;
                  next_wd_cnt = test_ind ? wd_cnt : wd_cnt + 32'h1;
               end else if (dly_cnt == 32'(RESET_DELAY - 1)) begin
                  next_rst_n = 1'b1;
               end else begin
                  next_dly_cnt = dly_cnt + 32'h1;
               end
            end else begin
               next_dly_cnt = '0;
            end
            if (rst_n && frame_evt) begin
               next_mode = sms_pkg::SMS_NORMAL;
               next_mode_bits = sms_pkg::MODE_SEL_NORMAL;
            end else if (rst_n && wd_expired) begin
               next_mode = sms_pkg::SMS_RESTART;
               next_wd_fail = 1'b1;
            end
         end
         sms_pkg::SMS_NORMAL, sms_pkg::SMS_STOP: begin
            if (wd_event && !(limit_bit && wd_resets == 2'(sms_pkg::MAX_WD_RESETS))) begin
               next_mode = sms_pkg::SMS_RESTART;
               next_fail_out = 1'b1;
               next_wd_resets = wd_resets + 2'h1;
            end else if (!rt_sync[1] && uvto_sync[1]) begin
               next_mode = sms_pkg::SMS_RESTART;
            end else if (frame_evt && cmd.write) begin
               case (cmd.mode_sel)
                  sms_pkg::MODE_SEL_NORMAL: next_mode = sms_pkg::SMS_NORMAL;
                  sms_pkg::MODE_SEL_STOP: next_mode = sms_pkg::SMS_STOP;
                  sms_pkg::MODE_SEL_SLEEP: next_mode = sms_pkg::SMS_SLEEP;
                  sms_pkg::MODE_SEL_RESET: next_mode = sms_pkg::SMS_INIT;
                  default: next_mode = mode;
               endcase
            end
            if (next_mode != mode) begin
               next_dly_cnt = '0;
               next_rst_n = (next_mode == sms_pkg::SMS_NORMAL || next_mode == sms_pkg::SMS_STOP);
            end
         end
         sms_pkg::SMS_SLEEP: begin
            next_rst_n = 1'b0;
            if (wake_sync[1]) begin
               next_mode = sms_pkg::SMS_RESTART;
            end
         end
         sms_pkg::SMS_RESTART: begin
            next_rst_n = 1'b0;
            next_mode_bits = sms_pkg::MODE_SEL_NORMAL;
            next_wd_cnt = '0;
            next_miss_cnt = sms_pkg::MISS_RESET;
            if (!rt_sync[1]) begin
               next_dly_cnt = '0;
            end else if (dly_cnt == 32'(RESET_DELAY - 1)) begin
               next_mode = sms_pkg::SMS_NORMAL;
               next_rst_n = 1'b1;
               next_dly_cnt = '0;
            end else begin
               next_dly_cnt = dly_cnt + 32'h1;
            end
         end
         sms_pkg::SMS_FAILSAFE: begin
            next_rst_n = 1'b0;
            next_dly_cnt = '0;
            if (wake_sync[1] && !ot_sync[1]) begin
               next_mode = sms_pkg::SMS_RESTART;
            end
         end
         default: next_mode = sms_pkg::SMS_INIT;
      endcase
      if (crit_sync[1] && mode != sms_pkg::SMS_FAILSAFE) begin
         next_mode = sms_pkg::SMS_FAILSAFE;
         next_rst_n = 1'b0;
      end
      if (soft_reset_i) begin
         next_mode = sms_pkg::SMS_INIT;
         next_rst_n = 1'b0;
         next_dly_cnt = '0;
         next_wd_cnt = '0;
      end
   end

   // Registers of the mode state machine.
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         mode <= sms_pkg::SMS_INIT;
         dly_cnt <= '0;
         wd_cnt <= '0;
         miss_cnt <= sms_pkg::MISS_RESET;
         wd_resets <= 2'h0;
         mode_bits <= sms_pkg::MODE_SEL_NORMAL;
         test_ind <= 1'b0;
         cfg_state <= 1'b1;
         limit_bit <= 1'b0;
         fail_out <= 1'b0;
         wd_fail <= 1'b0;
         uv_flag <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         mode <= next_mode;
         dly_cnt <= next_dly_cnt;
         wd_cnt <= next_wd_cnt;
         miss_cnt <= next_miss_cnt;
         wd_resets <= next_wd_resets;
         mode_bits <= next_mode_bits;
         test_ind <= next_test_ind;
         cfg_state <= next_cfg_state;
         limit_bit <= next_limit_bit;
         fail_out <= next_fail_out;
         wd_fail <= next_wd_fail;
         uv_flag <= next_uv_flag;
         rst_n <= next_rst_n;
      end
   end

   // Outputs; the strap pin is input in init and is pulled low outside init while the fail output is set.
   assign strap_pin_o = 1'b0;
   assign strap_pin_oe_o = (mode != sms_pkg::SMS_INIT) && fail_out;
   assign reset_output_n_o = rst_n;
   assign main_supply_en_o = (mode != sms_pkg::SMS_SLEEP) && (mode != sms_pkg::SMS_FAILSAFE);
   assign fail_outputs_o = fail_out;
   assign main_supply_undervoltage_flag_o = uv_flag;
   assign test_indication_o = test_ind;
   assign config_state_bit_o = cfg_state;
   assign watchdog_fail_o = wd_fail;
   assign mode_o = mode;

   // ****************************************************************
   // Checks.
   // ****************************************************************

   sleep_supply_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      mode == sms_pkg::SMS_SLEEP |-> !main_supply_en_o) else $error("Supply on in sleep.");

   stop_supply_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      mode == sms_pkg::SMS_STOP |-> main_supply_en_o) else $error("Supply off in stop.");

   restart_reset_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      mode == sms_pkg::SMS_RESTART |-> !reset_output_n_o) else $error("Reset released in restart.");

   restart_exit_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (mode == sms_pkg::SMS_RESTART && next_mode == sms_pkg::SMS_NORMAL)
      |=> reset_output_n_o && mode == sms_pkg::SMS_NORMAL) else $error("Restart exit wrong.");

   init_spi_a: assert property (@(posedge mclk_i) disable iff (reset_i || soft_reset_i || crit_sync[1])
      (mode == sms_pkg::SMS_INIT && rst_n && frame_evt) |=> mode == sms_pkg::SMS_NORMAL)
      else $error("Frame in init ignored.");

   dev_wd_a: assert property (@(posedge mclk_i) disable iff (reset_i || soft_reset_i)
      test_ind |=> $stable(wd_cnt)) else $error("Watchdog runs in development mode.");

   failsafe_hold_a: assert property (@(posedge mclk_i) disable iff (reset_i || soft_reset_i)
      (mode == sms_pkg::SMS_FAILSAFE && !wake_sync[1]) |=> mode == sms_pkg::SMS_FAILSAFE)
      else $error("Fail-safe left without wake.");

   mode_bits_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      mode == sms_pkg::SMS_RESTART |=> mode_bits == sms_pkg::MODE_SEL_NORMAL) else $error("Mode bits kept.");

   wd_restart_a: assert property (@(posedge mclk_i) disable iff (reset_i || soft_reset_i || crit_sync[1])
      (mode == sms_pkg::SMS_NORMAL && wd_event && !limit_bit) |=> mode == sms_pkg::SMS_RESTART && fail_out)
      else $error("Watchdog miss without restart.");

endmodule

//--- bench/sms_mcu_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Controller side of the serial link.
// ****************************************************************
module sms_mcu_model (
   input wire logic go_i,
   input wire logic [15:0] frame_i,
   output logic sclk_o,
   output logic csn_o,
   output logic mosi_o,
   output logic busy_o
);
   // The link clock stands still and the select stays high between frames.
   initial begin
      sclk_o = 1'b0;
      csn_o = 1'b1;
      mosi_o = 1'b0;
      busy_o = 1'b0;
   end
   // Each request sends one whole frame, highest bit first, on a 12 ns clock.
   always @(posedge go_i) begin
      busy_o = 1'b1;
      #3.7;
      csn_o = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         mosi_o = frame_i[i];
         #6;
         sclk_o = 1'b1;
         #6;
         sclk_o = 1'b0;
      end
      #6;
      csn_o = 1'b1;
      mosi_o = ~mosi_o; // Released data must not keep its last value.
      busy_o = 1'b0;
   end
endmodule

//--- bench/mode_select_bits_state_machine_bench.sv
`timescale 1ns/1ps
module mode_select_bits_state_machine_bench;
   // ****************************************************************
   // Stimulus and checks.
   // ****************************************************************
   localparam int RD = 8;
   localparam int LW = 64;
   logic mclk_i = 1'b0;
   logic reset_i = 1'b1;
   logic rt = 1'b0, uvto = 1'b0, wake = 1'b0, crit = 1'b0, otemp = 1'b0;
   logic srst = 1'b0, strap = 1'b1, go = 1'b0;
   logic [15:0] frame = 16'h0000;
   logic sclk, csn, mosi, busy, pin_o, pin_oe, rst_n, sup_en, fo, uv, tst, cfg, wdf;
   wire logic strap_w;
   sms_pkg::sms_mode_type mode, prev;
   int n_fail = 0;
   int samples_checked = 0;
   int n_rst = 0;
   int k;

   // The clock toggles every half period.
   always #10 mclk_i = ~mclk_i;

   // The strap line follows the bench strap level set by power_up unless the core pulls it low.
   assign strap_w = pin_oe ? pin_o : strap;

   // Entries into restart are counted.
   always @(posedge mclk_i) begin
      if (mode === sms_pkg::SMS_RESTART && prev !== sms_pkg::SMS_RESTART)
         n_rst++;
      prev <= mode;
   end

   sms_mcu_model sms_mcu_model_inst (.go_i(go), .frame_i(frame), .sclk_o(sclk), .csn_o(csn),
      .mosi_o(mosi), .busy_o(busy));

   sms_core #(.RESET_DELAY(RD), .LONG_WINDOW(LW)) sms_core_inst (.mclk_i(mclk_i), .reset_i(reset_i),
      .sclk_i(sclk), .csn_i(csn), .mosi_i(mosi), .supply_above_rt_i(rt), .supply_above_uvto_i(uvto),
      .wake_i(wake), .critical_fail_i(crit), .overtemp_i(otemp), .soft_reset_i(srst),
      .strap_pin_i(strap_w), .strap_pin_o(pin_o), .strap_pin_oe_o(pin_oe), .reset_output_n_o(rst_n),
      .main_supply_en_o(sup_en), .fail_outputs_o(fo), .main_supply_undervoltage_flag_o(uv),
      .test_indication_o(tst), .config_state_bit_o(cfg), .watchdog_fail_o(wdf), .mode_o(mode));

   // Waits whole cycles and lands just after the edge.
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask

   task automatic chk_bit(input string nm, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic chk_mode(input sms_pkg::sms_mode_type e);
      samples_checked++;
      if (mode !== e) begin
         n_fail++;
         $display("wrong value mode expected %s seen %s", e.name(), mode.name());
      end
   endtask

   task automatic results;
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Waits a bounded time for a mode; a miss ends the run.
   task automatic wait_mode(input sms_pkg::sms_mode_type e, input int lim);
      k = 0;
      while (mode !== e && k < lim) begin
         tick(1);
         k++;
      end
      chk_mode(e);
      if (mode !== e)
         results();
   endtask

   // Sends one frame through the model and keeps the spacing between frames.
   task automatic send(input logic [15:0] f);
      frame = f;
      go = 1'b1;
      tick(1);
      go = 1'b0;
      k = 0;
      while (busy !== 1'b0 && k < 50) begin
         tick(1);
         k++;
      end
      chk_bit("frame_done", 1'b1, k < 50);
      if (k >= 50)
         results();
      tick(6);
   endtask

   // Builds a write frame from mode, trigger, configuration and limit bits.
   function automatic logic [15:0] cmd(input logic [1:0] m, input logic t, input logic c, input logic l);
      return {1'b1, 10'h000, l, c, t, m};
   endfunction

   // Resets, ramps the supply and checks the init phase.
   task automatic power_up(input logic s);
      reset_i = 1'b1;
      rt = 1'b0;
      uvto = 1'b0;
      strap = s;
      tick(16);
      reset_i = 1'b0;
      tick(20);
      chk_mode(sms_pkg::SMS_INIT);
      chk_bit("reset_out", 1'b0, rst_n);
      chk_bit("uv_flag", 1'b0, uv);
      chk_bit("fail_out", 1'b0, fo);
      chk_bit("strap_oe", 1'b0, pin_oe);
      uvto = 1'b1;
      rt = 1'b1;
      k = 0;
      while (rst_n !== 1'b1 && k < 40) begin
         tick(1);
         k++;
      end
      chk_bit("release_delay", 1'b1, k >= RD && k <= RD + 6);
      chk_bit("test_ind", ~s, tst);
      wake = 1'b1;
      tick(5);
      chk_mode(sms_pkg::SMS_INIT);
      wake = 1'b0;
   endtask

   // Main sequence of scenarios.
   initial begin
      power_up(1'b1);
      send(16'h7ff0);
      wait_mode(sms_pkg::SMS_NORMAL, 10);
      chk_bit("cfg_state", 1'b1, cfg);
      send(cmd(sms_pkg::MODE_SEL_STOP, 1'b1, 1'b1, 1'b0));
      chk_mode(sms_pkg::SMS_STOP);
      chk_bit("supply_en", 1'b1, sup_en);
      send(cmd(sms_pkg::MODE_SEL_NORMAL, 1'b1, 1'b1, 1'b0));
      chk_mode(sms_pkg::SMS_NORMAL);
      send(cmd(sms_pkg::MODE_SEL_SLEEP, 1'b1, 1'b1, 1'b0));
      chk_mode(sms_pkg::SMS_SLEEP);
      chk_bit("supply_en", 1'b0, sup_en);
      wake = 1'b1;
      wait_mode(sms_pkg::SMS_RESTART, 10);
      wake = 1'b0;
      chk_bit("reset_out", 1'b0, rst_n);
      wait_mode(sms_pkg::SMS_NORMAL, 40);
      chk_bit("reset_out", 1'b1, rst_n);
      crit = 1'b1;
      wait_mode(sms_pkg::SMS_FAILSAFE, 10);
      chk_bit("supply_en", 1'b0, sup_en);
      crit = 1'b0;
      otemp = 1'b1;
      wake = 1'b1;
      tick(20);
      chk_mode(sms_pkg::SMS_FAILSAFE);
      otemp = 1'b0;
      wait_mode(sms_pkg::SMS_RESTART, 10);
      wake = 1'b0;
      wait_mode(sms_pkg::SMS_NORMAL, 40);
      send(cmd(sms_pkg::MODE_SEL_NORMAL, 1'b1, 1'b1, 1'b0));
      rt = 1'b0;
      wait_mode(sms_pkg::SMS_RESTART, 10);
      chk_bit("reset_out", 1'b0, rst_n);
      rt = 1'b1;
      wait_mode(sms_pkg::SMS_NORMAL, 40);
      n_rst = 0;
      tick(500);
      chk_bit("many_restarts", 1'b1, n_rst >= 4);
      chk_bit("wd_fail", 1'b1, wdf);
      chk_bit("fail_out", 1'b1, fo);
      wait_mode(sms_pkg::SMS_NORMAL, 90);
      send(cmd(sms_pkg::MODE_SEL_NORMAL, 1'b1, 1'b0, 1'b0));
      chk_bit("cfg_state", 1'b0, cfg);
      n_rst = 0;
      tick(LW + 20);
      chk_bit("one_miss", 1'b1, n_rst == 0);
      wait_mode(sms_pkg::SMS_RESTART, LW + 20);
      wait_mode(sms_pkg::SMS_NORMAL, 40);
      send(cmd(sms_pkg::MODE_SEL_NORMAL, 1'b1, 1'b1, 1'b1));
      n_rst = 0;
      tick(700);
      chk_bit("limited", 1'b1, n_rst == 3);
      chk_mode(sms_pkg::SMS_NORMAL);
      srst = 1'b1;
      tick(1);
      srst = 1'b0;
      wait_mode(sms_pkg::SMS_INIT, 10);
      power_up(1'b0);
      send(16'h7ff0);
      wait_mode(sms_pkg::SMS_NORMAL, 10);
      n_rst = 0;
      tick(300);
      chk_bit("no_wd_reset", 1'b1, n_rst == 0);
      chk_mode(sms_pkg::SMS_NORMAL);
      results();
   end
endmodule
